// ### usbepc_pkg.sv
// usbepc_pkg: shared constants and types for the endpoint control block
`default_nettype none
package usbepc_pkg;
  localparam logic [31:0] RXC_ADDR    = 32'h5000186e;
  localparam logic [31:0] EPC_ADDR    = 32'h50001870;
  localparam logic [31:0] TXD_ADDR    = 32'h50001872;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam int          RXC_RX_EN   = 0;
  localparam int          RXC_IGN     = 2;
  localparam int          RXC_FLUSH   = 3;
  localparam int          RXC_WARN_LO = 5;
  localparam int          RXC_WARN_HI = 6;
  localparam int          EPC_NUM_HI  = 3;
  localparam int          EPC_EN      = 4;
  localparam int          EPC_ISO     = 5;
  localparam int          EPC_STALL   = 7;
  localparam int          FIFO_DEPTH  = 64;
  localparam int          WARN_FREE1  = 4;
  localparam int          WARN_FREE2  = 8;
  localparam int          WARN_FREE3  = 16;
  localparam int          SETUP_BYTES = 8;
  localparam logic [7:0]  PID_DATA0   = 8'hc3;
  localparam logic [7:0]  PID_DATA1   = 8'h4b;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;

  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP, TOK_SOF} usbepc_tok_e;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} usbepc_hs_e;
  typedef enum logic [1:0] {RX_IDLE, RX_RECV, RX_DISCARD} usbepc_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_PID, TX_DATA, TX_CRC_LO, TX_CRC_HI} usbepc_tx_e;

  typedef struct packed {
    logic        valid;
    usbepc_tok_e pid;
    logic [6:0]  addr;
    logic [3:0]  ep;
  } usbepc_tok_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } usbepc_reg_s;

  // one byte of the reflected crc16 update
  function automatic logic [15:0] usbepc_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : usbepc_crc_byte
endpackage : usbepc_pkg
`default_nettype wire

// ### usbepc_fifo.sv
// usbepc_fifo: byte fifo with flush, count and fall-through head
`default_nettype none
module usbepc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = usbepc_pkg::FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_flush,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_head,
  output logic      [CW-1:0]    o_count,
  output logic                  o_full,
  output logic                  o_empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  wire              do_push = i_push && !o_full;
  wire              do_pop  = i_pop && !o_empty;

  assign o_count = cnt_q;
  assign o_full  = cnt_q == CW'(DEPTH);
  assign o_empty = cnt_q == '0;
  assign o_head  = mem[rd_q];

  always_ff @(posedge i_sys_clk) begin
    if (do_push) begin
      mem[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || i_flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= do_push ? wr_q + AW'(1) : wr_q;
      rd_q  <= do_pop ? rd_q + AW'(1) : rd_q;
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

  chk_fifo_flush_empty: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_flush |=> o_empty && wr_q == rd_q) else $error("fifo not empty after flush");
  chk_fifo_count_bound: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    cnt_q <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule : usbepc_fifo
`default_nettype wire

// ### usbepc_endpoint.sv
// usbepc_endpoint: endpoint control, configuration and fifo data registers
// Behaviour
// - warn limit field 6:5 picks threshold: off, under 5, under 9, under 17 free
// - free receive bytes at or below threshold sets the receive warning flag
// - writing flush bit 3 empties receive fifo, idles the receive state machine, resets pointers
// - flush requested during an ongoing reception waits until reception ends
// - ignore bit 2 set makes the endpoint disregard setup tokens to it
// - reception disarms after each received packet and after stalling an out token
// - setup packets are accepted whatever the receive enable bit says
// - back-to-back setup without other tokens between is dropped but acknowledged
// - setup refused for any other reason gets no handshake at all
// - stall bit 7 stalls in tokens and out tokens on an enabled endpoint
// - the stall bit never produces a stall answer to a setup token
// - iso bit 5 suppresses nak for empty transmit or full receive fifo
// - enable bit 4 matches endpoint number together with the function address
// - with enable bit clear the endpoint answers no token at all
// - bits 3:0 hold the endpoint number used for token matching
// - transmitter adds the data pid and crc16 around the payload itself
// - in test mode the transmit data register is readable from the core bus
// - receiver strips pid and crc16, so the fifo holds only payload bytes
// - media error on reception is flagged; firmware then flushes the fifo
`default_nettype none
module usbepc_endpoint #(
  parameter int RX_DEPTH = usbepc_pkg::FIFO_DEPTH,
  parameter int TX_DEPTH = usbepc_pkg::FIFO_DEPTH,
  parameter int RCW      = $clog2(RX_DEPTH + 1)
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset,
  input  wire usbepc_pkg::usbepc_reg_s i_reg,
  output logic [15:0]                   o_reg_rdata,
  input  wire logic                     i_test_mode,
  input  wire logic [6:0]               i_function_address,
  input  wire usbepc_pkg::usbepc_tok_s i_tok,
  input  wire logic                     i_rx_valid,
  input  wire logic [7:0]               i_rx_byte,
  input  wire logic                     i_rx_eop,
  input  wire logic                     i_rx_err,
  output logic                          o_hs_valid,
  output usbepc_pkg::usbepc_hs_e        o_hs_code,
  input  wire logic                     i_tx_ready,
  output logic                          o_tx_valid,
  output logic [7:0]                    o_tx_byte,
  output logic                          o_tx_last,
  input  wire logic                     i_rx_fifo_pop,
  output logic [7:0]                    o_rx_fifo_byte,
  output logic                          o_rx_fifo_empty,
  output logic [RCW-1:0]                o_rx_free_count,
  input  wire logic                     i_rx_warn_clear,
  output logic                          o_rx_warn_flag,
  output logic                          o_rx_media_err
);
  localparam int TCW = $clog2(TX_DEPTH + 1);

  usbepc_pkg::usbepc_rx_e rx_state_q;
  usbepc_pkg::usbepc_tx_e tx_state_q;
  usbepc_pkg::usbepc_hs_e hs_code_q;
  usbepc_pkg::usbepc_hs_e disc_code_q;
  logic        rx_en_q, ign_q, flush_pend_q, stall_q, iso_q, ep_en_q;
  logic [1:0]  warn_lim_q;
  logic [3:0]  ep_num_q;
  logic        setup_seen_q, disc_hs_q, rx_bad_q, media_err_q, warn_q;
  logic        hs_valid_q, toggle_q;
  logic [1:0]  rx_n_q;
  logic [7:0]  hold0_q, hold1_q, tx_byte_q;
  logic [15:0] crc_q, rdata_q;
  logic [RCW-1:0] rx_count;
  logic [TCW-1:0] tx_count;
  logic [7:0]  tx_head;
  logic        rx_full, tx_empty, tx_full;

  // register decode
  wire sel_rxc = i_reg.addr == usbepc_pkg::RXC_ADDR;
  wire sel_epc = i_reg.addr == usbepc_pkg::EPC_ADDR;
  wire sel_txd = i_reg.addr == usbepc_pkg::TXD_ADDR;
  wire wr_rxc  = i_reg.wr && sel_rxc;
  wire wr_epc  = i_reg.wr && sel_epc;
  wire wr_txd  = i_reg.wr && sel_txd;
  wire test_rd = i_reg.rd && sel_txd && i_test_mode;

  // token decisions
  wire tok_match  = i_tok.valid && ep_en_q && i_tok.addr == i_function_address
                    && i_tok.ep == ep_num_q;
  wire tok_go     = tok_match && rx_state_q == usbepc_pkg::RX_IDLE
                    && tx_state_q == usbepc_pkg::TX_IDLE && !flush_pend_q;
  wire is_setup   = i_tok.pid == usbepc_pkg::TOK_SETUP;
  wire is_in      = i_tok.pid == usbepc_pkg::TOK_IN;
  wire is_out     = i_tok.pid == usbepc_pkg::TOK_OUT;
  wire setup_take = tok_go && is_setup && !ign_q;
  wire setup_room = o_rx_free_count >= RCW'(usbepc_pkg::SETUP_BYTES);
  wire out_take   = tok_go && is_out && !stall_q;
  wire rx_start   = (setup_take && !setup_seen_q && setup_room)
                    || (out_take && rx_en_q && !rx_full);
  wire rx_drop    = (setup_take && !rx_start) || (out_take && !rx_start);
  wire drop_hs    = setup_take ? setup_seen_q : !iso_q;
  wire stall_hit  = tok_go && stall_q && (is_in || is_out);
  wire in_nak     = tok_go && is_in && !stall_q && tx_empty && !iso_q;
  wire tx_start   = tok_go && is_in && !stall_q && !tx_empty;

  // receive path
  wire rx_recv  = rx_state_q == usbepc_pkg::RX_RECV;
  wire rx_end   = rx_recv && i_rx_eop;
  wire rx_good  = rx_end && !i_rx_err && !rx_bad_q;
  wire rx_push  = rx_recv && i_rx_valid && rx_n_q == 2'h3;
  wire rx_flush = flush_pend_q && !rx_recv;
  wire disc_end = rx_state_q == usbepc_pkg::RX_DISCARD && i_rx_eop;

  // handshake selection
  wire hs_valid_d = stall_hit || in_nak || (rx_good && !iso_q) || (disc_end && disc_hs_q);
  usbepc_pkg::usbepc_hs_e hs_code_d;
  assign hs_code_d = stall_hit ? usbepc_pkg::HS_STALL :
                     in_nak    ? usbepc_pkg::HS_NAK :
                     rx_good   ? usbepc_pkg::HS_ACK : disc_code_q;

  // warning threshold
  logic [RCW-1:0] warn_thr;
  assign warn_thr = (warn_lim_q == 2'h1) ? RCW'(usbepc_pkg::WARN_FREE1) :
                    (warn_lim_q == 2'h2) ? RCW'(usbepc_pkg::WARN_FREE2) :
                                           RCW'(usbepc_pkg::WARN_FREE3);
  wire warn_hit = warn_lim_q != 2'h0 && o_rx_free_count <= warn_thr;

  // transmit path
  wire        tx_hs     = o_tx_valid && i_tx_ready;
  wire        tx_in_pay = tx_state_q == usbepc_pkg::TX_PID || tx_state_q == usbepc_pkg::TX_DATA;
  wire        tx_pop    = (tx_hs && tx_in_pay && !tx_empty) || test_rd;
  wire [15:0] crc_next  = usbepc_pkg::usbepc_crc_byte(crc_q, tx_head);
  wire [15:0] crc_fin   = ~crc_q;

  // read data
  wire [15:0] rxc_val = {9'h000, warn_lim_q, 1'b0, flush_pend_q, ign_q, 1'b0, rx_en_q};
  wire [15:0] epc_val = {8'h00, stall_q, 1'b0, iso_q, ep_en_q, ep_num_q};
  wire [15:0] txd_val = i_test_mode ? {8'h00, tx_head} : 16'h0000;
  wire [15:0] rdata_d = sel_rxc ? rxc_val : sel_epc ? epc_val : sel_txd ? txd_val : 16'h0000;

  assign o_reg_rdata     = rdata_q;
  assign o_hs_valid      = hs_valid_q;
  assign o_hs_code       = hs_code_q;
  assign o_tx_valid      = tx_state_q != usbepc_pkg::TX_IDLE;
  assign o_tx_byte       = tx_byte_q;
  assign o_tx_last       = tx_state_q == usbepc_pkg::TX_CRC_HI;
  assign o_rx_free_count = RCW'(RX_DEPTH) - rx_count;
  assign o_rx_warn_flag  = warn_q;
  assign o_rx_media_err  = media_err_q;

  usbepc_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_flush   (rx_flush),
    .i_push    (rx_push),
    .i_data    (hold0_q),
    .i_pop     (i_rx_fifo_pop),
    .o_head    (o_rx_fifo_byte),
    .o_count   (rx_count),
    .o_full    (rx_full),
    .o_empty   (o_rx_fifo_empty)
  );

  usbepc_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_flush   (1'b0),
    .i_push    (wr_txd),
    .i_data    (i_reg.wdata[7:0]),
    .i_pop     (tx_pop),
    .o_head    (tx_head),
    .o_count   (tx_count),
    .o_full    (tx_full),
    .o_empty   (tx_empty)
  );

  // configuration and control fields
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      {warn_lim_q, ign_q} <= '0;
      {stall_q, iso_q, ep_en_q, ep_num_q} <= '0;
    end else begin
      if (wr_rxc) begin
        warn_lim_q <= i_reg.wdata[usbepc_pkg::RXC_WARN_HI:usbepc_pkg::RXC_WARN_LO];
        ign_q      <= i_reg.wdata[usbepc_pkg::RXC_IGN];
      end
      if (wr_epc) begin
        stall_q  <= i_reg.wdata[usbepc_pkg::EPC_STALL];
        iso_q    <= i_reg.wdata[usbepc_pkg::EPC_ISO];
        ep_en_q  <= i_reg.wdata[usbepc_pkg::EPC_EN];
        ep_num_q <= i_reg.wdata[usbepc_pkg::EPC_NUM_HI:0];
      end
    end
  end

  // receive enable, flush request and sticky flags
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      {rx_en_q, flush_pend_q, media_err_q, warn_q} <= '0;
    end else begin
      if (wr_rxc) begin
        rx_en_q <= i_reg.wdata[usbepc_pkg::RXC_RX_EN];
      end else if (rx_end || (stall_hit && is_out)) begin
        rx_en_q <= 1'b0;
      end
      flush_pend_q <= (wr_rxc && i_reg.wdata[usbepc_pkg::RXC_FLUSH]) || (flush_pend_q && !rx_flush);
      media_err_q  <= (rx_end && i_rx_err) || (media_err_q && !rx_flush);
      warn_q       <= warn_hit || (warn_q && !i_rx_warn_clear);
    end
  end

  // receive state machine
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || rx_flush) begin
      rx_state_q   <= usbepc_pkg::RX_IDLE;
      setup_seen_q <= 1'b0;
      {disc_hs_q, rx_bad_q, rx_n_q} <= '0;
      disc_code_q  <= usbepc_pkg::HS_ACK;
    end else begin
      case (rx_state_q)
        usbepc_pkg::RX_IDLE: begin
          rx_n_q   <= '0;
          rx_bad_q <= 1'b0;
          if (tok_go && (is_in || is_out)) begin
            setup_seen_q <= 1'b0;
          end
          if (rx_start) begin
            rx_state_q <= usbepc_pkg::RX_RECV;
            if (setup_take) begin
              setup_seen_q <= 1'b1;
            end
          end else if (rx_drop) begin
            rx_state_q  <= usbepc_pkg::RX_DISCARD;
            disc_hs_q   <= drop_hs;
            disc_code_q <= setup_take ? usbepc_pkg::HS_ACK : usbepc_pkg::HS_NAK;
          end
        end
        usbepc_pkg::RX_RECV: begin
          if (i_rx_valid) begin
            rx_n_q  <= (rx_n_q == 2'h3) ? rx_n_q : rx_n_q + 2'h1;
            hold0_q <= (rx_n_q == 2'h1 || rx_n_q == 2'h3) ? (rx_n_q == 2'h1 ? i_rx_byte : hold1_q) : hold0_q;
            hold1_q <= (rx_n_q >= 2'h2) ? i_rx_byte : hold1_q;
            rx_bad_q <= rx_bad_q || (rx_push && rx_full);
          end
          if (i_rx_eop) begin
            rx_state_q <= usbepc_pkg::RX_IDLE;
          end
        end
        usbepc_pkg::RX_DISCARD: begin
          if (i_rx_eop) begin
            rx_state_q <= usbepc_pkg::RX_IDLE;
          end
        end
        default: rx_state_q <= usbepc_pkg::RX_IDLE;
      endcase
    end
  end

  // handshake and read data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      hs_valid_q <= 1'b0;
      hs_code_q  <= usbepc_pkg::HS_ACK;
      rdata_q    <= usbepc_pkg::REG_RESET;
    end else begin
      hs_valid_q <= hs_valid_d;
      hs_code_q  <= hs_valid_d ? hs_code_d : hs_code_q;
      rdata_q    <= i_reg.rd ? rdata_d : rdata_q;
    end
  end

  // transmit state machine
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tx_state_q <= usbepc_pkg::TX_IDLE;
      tx_byte_q  <= '0;
      crc_q      <= usbepc_pkg::CRC_INIT;
      toggle_q   <= 1'b0;
    end else begin
      case (tx_state_q)
        usbepc_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state_q <= usbepc_pkg::TX_PID;
            tx_byte_q  <= toggle_q ? usbepc_pkg::PID_DATA1 : usbepc_pkg::PID_DATA0;
            crc_q      <= usbepc_pkg::CRC_INIT;
          end
        end
        usbepc_pkg::TX_PID, usbepc_pkg::TX_DATA: begin
          if (tx_hs && !tx_empty) begin
            tx_state_q <= usbepc_pkg::TX_DATA;
            tx_byte_q  <= tx_head;
            crc_q      <= crc_next;
          end else if (tx_hs) begin
            tx_state_q <= usbepc_pkg::TX_CRC_LO;
            tx_byte_q  <= crc_fin[7:0];
          end
        end
        usbepc_pkg::TX_CRC_LO: begin
          if (tx_hs) begin
            tx_state_q <= usbepc_pkg::TX_CRC_HI;
            tx_byte_q  <= crc_fin[15:8];
          end
        end
        usbepc_pkg::TX_CRC_HI: begin
          if (tx_hs) begin
            tx_state_q <= usbepc_pkg::TX_IDLE;
            toggle_q   <= !toggle_q;
          end
        end
        default: tx_state_q <= usbepc_pkg::TX_IDLE;
      endcase
    end
  end

  chk_warn_level_one: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (warn_lim_q == 2'h1 && o_rx_free_count <= RCW'(4)) |=> o_rx_warn_flag)
    else $error("warn flag missed at limit one");
  chk_warn_off_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (warn_lim_q == 2'h0 && !o_rx_warn_flag) |=> !o_rx_warn_flag)
    else $error("warn flag set while disabled");
  chk_flush_empties: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rx_flush |=> o_rx_fifo_empty && rx_state_q == usbepc_pkg::RX_IDLE && !flush_pend_q)
    else $error("flush left data or state");
  chk_flush_waits: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (flush_pend_q && rx_recv) |-> !rx_flush)
    else $error("flush during reception");
  chk_setup_ignored: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (tok_go && is_setup && ign_q) |=> rx_state_q == usbepc_pkg::RX_IDLE && !o_hs_valid)
    else $error("ignored setup was handled");
  chk_rx_disarm: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (rx_end && !wr_rxc) |=> !rx_en_q)
    else $error("receive stayed armed after packet");
  chk_setup_no_enable: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (setup_take && !rx_en_q && !setup_seen_q && setup_room) |=> rx_recv)
    else $error("setup refused while disarmed");
  chk_b2b_setup_ack: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (setup_take && setup_seen_q) |=> rx_state_q == usbepc_pkg::RX_DISCARD && disc_hs_q
    && disc_code_q == usbepc_pkg::HS_ACK)
    else $error("back to back setup not acknowledged");
  chk_stall_in: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (tok_go && is_in && stall_q) |=> o_hs_valid && o_hs_code == usbepc_pkg::HS_STALL)
    else $error("in token not stalled");
  chk_setup_no_stall: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (tok_go && is_setup && stall_q) |=> !o_hs_valid)
    else $error("setup answered by stall");
  chk_iso_no_nak: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (o_hs_valid && $past(iso_q)) |-> o_hs_code != usbepc_pkg::HS_NAK)
    else $error("nak sent on iso endpoint");
  chk_disabled_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_tok.valid && !ep_en_q && !o_tx_valid) |=> !o_tx_valid)
    else $error("disabled endpoint answered");
  chk_tx_pid_first: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (tx_state_q == usbepc_pkg::TX_IDLE ##1 o_tx_valid)
    |-> (o_tx_byte == usbepc_pkg::PID_DATA0 || o_tx_byte == usbepc_pkg::PID_DATA1))
    else $error("packet did not start with data pid");
endmodule : usbepc_endpoint
`default_nettype wire

// ### usbepc_host.sv
// usbepc_host: behavioural bus-side controller model for the endpoint
`default_nettype none
module usbepc_host (
  input  wire logic               i_sys_clk,
  input  wire logic               i_slow,
  output usbepc_pkg::usbepc_tok_s o_tok,
  output logic                    o_rx_valid,
  output logic [7:0]              o_rx_byte,
  output logic                    o_rx_eop,
  output logic                    o_rx_err,
  input  wire logic               i_tx_valid,
  input  wire logic [7:0]         i_tx_byte,
  output logic                    o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_q[$];
  logic       bad = 1'b0;
  initial begin
    o_tok = '0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_rx_eop = 1'b0;
    o_rx_err = 1'b0;
    o_tx_ready = 1'b0;
  end
  // one-cycle token
  task automatic tok(input usbepc_pkg::usbepc_tok_e p, input logic [6:0] a, input logic [3:0] e);
    @(negedge i_sys_clk);
    o_tok <= '{1'b1, p, a, e};
    @(negedge i_sys_clk);
    o_tok.valid <= 1'b0;
  endtask : tok
  // pid, payload and crc bytes, then end of packet; idle line shows inverse
  task automatic pkt(input logic [7:0] d[$]);
    foreach (d[i]) begin
      @(negedge i_sys_clk);
      o_rx_valid <= 1'b1;
      o_rx_byte <= d[i];
    end
    @(negedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_byte <= ~o_rx_byte;
    o_rx_eop <= 1'b1;
    o_rx_err <= bad;
    @(negedge i_sys_clk);
    o_rx_eop <= 1'b0;
    o_rx_err <= 1'b0;
  endtask : pkt
  // prompt or slow acceptance of transmit bytes
  always @(negedge i_sys_clk) o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
  always @(posedge i_sys_clk) if (i_tx_valid && o_tx_ready) tx_q.push_back(i_tx_byte);
endmodule : usbepc_host
`default_nettype wire

// ### tb_usbepc_endpoint.sv
// tb_usbepc_endpoint: self-checking bench for the endpoint control block
`default_nettype none
module tb_usbepc_endpoint;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_RX = usbepc_pkg::RXC_ADDR;
  localparam logic [31:0] A_EP = usbepc_pkg::EPC_ADDR;
  localparam logic [31:0] A_TX = usbepc_pkg::TXD_ADDR;
  logic sys_clk, reset, test_mode, tx_ready, rx_valid, rx_eop, rx_err, pop, warn_clr, slow;
  logic hs_v, tx_v, tx_last, rx_empty, warn, merr;
  logic [6:0] fad, free;
  logic [7:0] rx_byte, tx_b, rx_head;
  logic [15:0] rdata, w;
  logic [3:0] ep;
  logic [31:0] seed = 32'h1f77e835;
  logic [7:0] pl[$], exp_q[$];
  int fails, compares, cyc, hs_n, nhs, lst;
  usbepc_pkg::usbepc_reg_s rq;
  usbepc_pkg::usbepc_tok_s tok;
  usbepc_pkg::usbepc_hs_e hs_c;
  usbepc_endpoint i_usbepc_endpoint (.i_sys_clk(sys_clk), .i_reset(reset), .i_reg(rq), .o_reg_rdata(rdata),
    .i_test_mode(test_mode), .i_function_address(fad), .i_tok(tok), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .i_rx_eop(rx_eop), .i_rx_err(rx_err), .o_hs_valid(hs_v), .o_hs_code(hs_c),
    .i_tx_ready(tx_ready), .o_tx_valid(tx_v), .o_tx_byte(tx_b), .o_tx_last(tx_last), .i_rx_fifo_pop(pop),
    .o_rx_fifo_byte(rx_head), .o_rx_fifo_empty(rx_empty), .o_rx_free_count(free),
    .i_rx_warn_clear(warn_clr), .o_rx_warn_flag(warn), .o_rx_media_err(merr));
  usbepc_host i_usbepc_host (.i_sys_clk(sys_clk), .i_slow(slow), .o_tok(tok), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_rx_eop(rx_eop), .o_rx_err(rx_err), .i_tx_valid(tx_v), .i_tx_byte(tx_b),
    .o_tx_ready(tx_ready));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (d[i]) begin
      c ^= {8'h00, d[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return ~c;
  endfunction : crc16
  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    rq <= '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    rq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] e, input string m);
    @(negedge sys_clk);
    rq <= '{1'b0, 1'b1, a, 16'h0000};
    @(negedge sys_clk);
    rq.rd <= 1'b0;
    chk(rdata, e, m);
  endtask : rd
  // token, then a data packet of n payload bytes when n is not zero
  task automatic xfer(input usbepc_pkg::usbepc_tok_e p, input logic [3:0] e, input int n);
    logic [7:0] d[$];
    logic [15:0] c;
    int h0;
    h0 = hs_n;
    pl = {};
    for (int i = 0; i < n; i++) pl.push_back(rnd());
    c = crc16(pl);
    d = {usbepc_pkg::PID_DATA0, pl, c[7:0], c[15:8]};
    i_usbepc_host.tok(p, fad, e);
    if (n > 0) i_usbepc_host.pkt(d);
    repeat (3) @(negedge sys_clk);
    nhs = hs_n - h0;
  endtask : xfer
  task automatic ans(input int n, input usbepc_pkg::usbepc_hs_e c);
    chk(16'(nhs), 16'(n), "handshake count");
    if (n != 0) chk(16'(hs_c), 16'(c), "handshake code");
  endtask : ans
  task automatic drain();
    while (exp_q.size() > 0) begin
      chk(16'(rx_head), 16'(exp_q.pop_front()), "rx fifo byte");
      @(negedge sys_clk);
      pop <= 1'b1;
      @(negedge sys_clk);
      pop <= 1'b0;
    end
    chk(16'(rx_empty), 16'h0001, "rx fifo empty");
  endtask : drain
  always @(posedge sys_clk) begin
    cyc++;
    if (hs_v) hs_n++;
    if (tx_v && tx_ready && tx_last) lst++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    logic [7:0] d[$];
    logic [15:0] c;
    {reset, test_mode, pop, warn_clr, slow, fad, rq} = {1'b1, 4'h0, 7'h00, 50'h0};
    repeat (8) @(negedge sys_clk);
    reset <= 1'b0;
    rd(A_RX, 16'h0000, "rxc reset");
    rd(A_EP, 16'h0000, "epc reset");
    chk(16'(free), 16'd64, "free reset");
    for (int i = 0; i < 8; i++) begin
      w = {rnd(), rnd()};
      wr(A_EP, w);
      rd(A_EP, w & 16'h00bf, "epc fields");
      wr(A_RX, w & 16'hfff7);
      rd(A_RX, w & 16'h0065, "rxc fields");
    end
    rd(32'h50001878, 16'h0000, "unmapped");
    $display("registers done");
    fad = 7'(rnd());
    ep = 4'(rnd());
    wr(A_EP, 16'h0010 | 16'(ep));
    wr(A_RX, 16'h0001);
    xfer(usbepc_pkg::TOK_OUT, ep, 5);
    ans(1, usbepc_pkg::HS_ACK);
    exp_q = pl;
    rd(A_RX, 16'h0000, "disarmed");
    xfer(usbepc_pkg::TOK_OUT, ep, 3);
    ans(1, usbepc_pkg::HS_NAK);
    drain();
    xfer(usbepc_pkg::TOK_OUT, 4'(ep + 1), 3);
    ans(0, usbepc_pkg::HS_ACK);
    xfer(usbepc_pkg::TOK_SETUP, ep, 8);
    ans(1, usbepc_pkg::HS_ACK);
    exp_q = pl;
    xfer(usbepc_pkg::TOK_SETUP, ep, 8);
    ans(1, usbepc_pkg::HS_ACK);
    drain();
    xfer(usbepc_pkg::TOK_IN, ep, 0);
    ans(1, usbepc_pkg::HS_NAK);
    wr(A_RX, 16'h0004);
    xfer(usbepc_pkg::TOK_SETUP, ep, 8);
    ans(0, usbepc_pkg::HS_ACK);
    wr(A_EP, 16'h0030 | 16'(ep));
    xfer(usbepc_pkg::TOK_IN, ep, 0);
    ans(0, usbepc_pkg::HS_ACK);
    wr(A_EP, 16'h0090 | 16'(ep));
    wr(A_RX, 16'h0001);
    xfer(usbepc_pkg::TOK_OUT, ep, 2);
    ans(1, usbepc_pkg::HS_STALL);
    rd(A_RX, 16'h0000, "stall disarms");
    xfer(usbepc_pkg::TOK_IN, ep, 0);
    ans(1, usbepc_pkg::HS_STALL);
    xfer(usbepc_pkg::TOK_SETUP, ep, 8);
    ans(1, usbepc_pkg::HS_ACK);
    wr(A_RX, 16'h0008);
    @(negedge sys_clk);
    chk(16'(free), 16'd64, "flushed");
    wr(A_EP, 16'(ep));
    xfer(usbepc_pkg::TOK_SETUP, ep, 8);
    ans(0, usbepc_pkg::HS_ACK);
    $display("tokens done");
    wr(A_EP, 16'h0010 | 16'(ep));
    for (int t = 0; t < 2; t++) begin
      d = {};
      for (int i = 0; i <= t * 6; i++) d.push_back(rnd());
      foreach (d[i]) wr(A_TX, {rnd(), d[i]});
      slow <= t[0];
      i_usbepc_host.tx_q = {};
      i_usbepc_host.tok(usbepc_pkg::TOK_IN, fad, ep);
      repeat (40) @(negedge sys_clk);
      c = crc16(d);
      d = {t ? usbepc_pkg::PID_DATA1 : usbepc_pkg::PID_DATA0, d, c[7:0], c[15:8]};
      chk(16'(i_usbepc_host.tx_q.size()), 16'(d.size()), "tx length");
      foreach (d[i]) chk(16'(i_usbepc_host.tx_q[i]), 16'(d[i]), "tx byte");
      chk(16'(lst), 16'(t + 1), "tx last");
    end
    wr(A_TX, 16'h005a);
    rd(A_TX, 16'h0000, "tx read off");
    test_mode <= 1'b1;
    rd(A_TX, 16'h005a, "tx read test");
    test_mode <= 1'b0;
    xfer(usbepc_pkg::TOK_IN, ep, 0);
    ans(1, usbepc_pkg::HS_NAK);
    $display("transmit done");
    wr(A_RX, 16'h0001);
    i_usbepc_host.bad = 1'b1;
    xfer(usbepc_pkg::TOK_OUT, ep, 2);
    i_usbepc_host.bad = 1'b0;
    ans(0, usbepc_pkg::HS_ACK);
    chk(16'(merr), 16'h0001, "media error set");
    for (int l = 0; l < 4; l++) begin
      wr(A_RX, 16'h0008);
      warn_clr <= 1'b1;
      @(negedge sys_clk);
      warn_clr <= 1'b0;
      chk(16'(merr), 16'h0000, "media error cleared");
      for (int k = 1; k <= 8; k++) begin
        wr(A_RX, 16'(l << 5) | 16'h0001);
        xfer(usbepc_pkg::TOK_OUT, ep, 8);
        chk(16'(warn), 16'(l > 0 && 64 - 8 * k <= (2 << l)), "warn flag");
      end
    end
    $display("warning done");
    wrap_up();
  end
endmodule : tb_usbepc_endpoint
`default_nettype wire
